/* File: inc/sbc_mode_map.svh */
// constants of the operating-mode controller
// Function
// - host requests mode via mode field; field clears passing through restart.
// - wake in normal or stop pulses wake interrupt, mode unchanged.
// - entering normal from init: auxiliary regulator off, CAN and LIN off.
// - normal mode defaults: first/third fail outputs off, failsafe input active.
// - fail-output test bit drives fail outputs active, in normal mode only.
// - stop mode ignores writes and flags SPI error, except exempt writes and mode requests for normal or soft reset.
// - stop mode freezes boost, auxiliary, CAN, LIN, wake and cyclic settings.
// - stop-to-sleep request sets SPI error and enters restart instead.
// - sleep wake goes through restart to normal, recording the wake source.
// - entering sleep turns normal or receive-only transceivers wake-capable.
// - sleep mode discards SPI commands and gives no serial response.
// - wake flags still set at sleep entry cause immediate wake via restart.
// - accepted sleep command drives reset output low at once.
// - normal/stop enter restart on undervoltage, bad watchdog, enabled overvoltage.
// - sleep enters restart on wake; there is no fail-safe mode.
// - device state field 01 for faults, 10 after sleep wake; watchdog field 00.
// - undervoltage restart sets uv=1 ov=0; overvoltage restart sets ov=1 uv=0.
// - with reset-limit enable, no watchdog resets once three have been counted, consecutive or not.
// - restart holds reset low; after cause clears and delay, enter normal.
// - entering or leaving restart leaves fail outputs unchanged.
// - restart disables auxiliary regulator and ignores all SPI traffic.
// - restart makes transceivers wake-capable if previously active, else unchanged.
// - overvoltage restart disabled after reset until enable bit is set.
`ifndef SBC_MODE_MAP_SVH
`define SBC_MODE_MAP_SVH

// ****
// mode field encodings
// ****
`define REQ_NORMAL 2'h0
`define REQ_SLEEP 2'h1
`define REQ_STOP 2'h2
`define REQ_SOFT_RESET 2'h3

// ****
// transceiver state encodings
// ****
`define TRX_OFF 2'h0
`define TRX_WAKE 2'h1
`define TRX_RXONLY 2'h2
`define TRX_NORMAL 2'h3

// ****
// status codes and reset values
// ****
`define DEVICE_STATE_FIELD_FAULT 2'h1
`define DEVICE_STATE_FIELD_WAKE 2'h2
`define DEVICE_STATE_FIELD_RESET 2'h0
`define WATCHDOG_FAILURE_FIELD_NONE 2'h0
`define WD_RST_LIMIT 2'h3

// ****
// timing: reset delay in microseconds
// ****
`define RESET_DELAY_US 10
`define CLK_MHZ 50
`define RESET_DELAY_CYC (`RESET_DELAY_US * `CLK_MHZ)

`endif

/* File: inc/sbc_mode_pkg.sv */
// types of the operating-mode controller
package sbc_mode_pkg;
    typedef enum logic [4:0]
    {
        ST_INIT = 5'h01,
        ST_NORMAL = 5'h02,
        ST_STOP = 5'h04,
        ST_SLEEP = 5'h08,
        ST_RESTART = 5'h10
    } mode_t;
endpackage

/* File: src/pin_sync.sv */
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module pin_sync
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // pin and filtered level
    input wire logic pin_i,
    output logic level_o
);
    logic s1_r, s2_r, s3_r, level_r;
    logic level_nxt;

    // a change counts once stages two and three agree
    always_comb
    begin
        level_nxt = level_r;
        if (s2_r == s3_r)
            level_nxt = s3_r;
    end

    // first stage only feeds the second
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            level_r <= 1'b0;
        end
        else
        begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
        end
    end

    assign level_o = level_r;
endmodule

/* File: src/sbc_mode_ctrl.sv */
// operating-mode controller: mode state, frozen settings, restart causes
`timescale 1ns/1ps
`include "sbc_mode_map.svh"
module sbc_mode_ctrl
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // decoded spi write from the spi front end (same clock)
    input wire logic spi_wr_i,
    input wire logic spi_mode_wr_i,
    input wire logic [1:0] spi_mode_i,
    input wire logic spi_exempt_i,
    input wire logic spi_cfg_wr_i,
    input wire logic aux_on_i,
    input wire logic boost_on_i,
    input wire logic [1:0] can_cfg_i,
    input wire logic [1:0] lin_cfg_i,
    input wire logic wake_in_en_i,
    input wire logic cyclic_en_i,
    input wire logic fo_test_i,
    input wire logic fsi_as_fo_i,
    input wire logic ov_rst_en_i,
    input wire logic rst_limit_en_i,
    input wire logic wake_flags_set_i,
    // events from analog monitors and watchdog (pins)
    input wire logic can_wake_i,
    input wire logic lin_wake_i,
    input wire logic wk_wake_i,
    input wire logic uv_i,
    input wire logic ov_i,
    input wire logic watchdog_failure_field_i,
    // mode and spi control outputs
    output logic [2:0] mode_o,
    output logic [1:0] mode_field_o,
    output logic spi_err_o,
    output logic spi_ignore_o,
    output logic spi_sdo_en_o,
    // pins toward the host
    output logic reset_out_n_o,
    output logic wake_int_o,
    // supply and peripheral settings
    output logic aux_on_o,
    output logic boost_on_o,
    output logic [1:0] can_mode_o,
    output logic [1:0] lin_mode_o,
    output logic wake_in_en_o,
    output logic cyclic_en_o,
    output logic first_fail_output_o,
    output logic third_fail_output_o,
    output logic failsafe_input_en_o,
    // status fields
    output logic [1:0] dev_state_o,
    output logic [1:0] watchdog_failure_field_o,
    output logic uv_flag_o,
    output logic ov_flag_o,
    output logic [2:0] wake_src_o
);
    // ****
    // pin synchronisers
    // ****
    logic can_w, lin_w, wk_w, uv_w, ov_w, wd_w;
    pin_sync u_can (.clk_i(clk_i), .reset_n_i(reset_n_i), .pin_i(can_wake_i), .level_o(can_w));
    pin_sync u_lin (.clk_i(clk_i), .reset_n_i(reset_n_i), .pin_i(lin_wake_i), .level_o(lin_w));
    pin_sync u_wk (.clk_i(clk_i), .reset_n_i(reset_n_i), .pin_i(wk_wake_i), .level_o(wk_w));
    pin_sync u_uv (.clk_i(clk_i), .reset_n_i(reset_n_i), .pin_i(uv_i), .level_o(uv_w));
    pin_sync u_ov (.clk_i(clk_i), .reset_n_i(reset_n_i), .pin_i(ov_i), .level_o(ov_w));
    pin_sync u_wd (.clk_i(clk_i), .reset_n_i(reset_n_i), .pin_i(watchdog_failure_field_i), .level_o(wd_w));

    // ****
    // state
    // ****
    sbc_mode_pkg::mode_t mode_r, mode_nxt;
    logic [1:0] field_r, field_nxt, dev_r, dev_nxt, wdf_r, wdf_nxt, wdcnt_r, wdcnt_nxt;
    logic [1:0] can_r, can_nxt, lin_r, lin_nxt;
    logic aux_r, aux_nxt, boost_r, boost_nxt, wkin_r, wkin_nxt, cyc_r, cyc_nxt;
    logic fo_r, fo_nxt, fsi_r, fsi_nxt, err_r, err_nxt, int_r, int_nxt;
    logic uvf_r, uvf_nxt, ovf_r, ovf_nxt, wdw_d_r;
    logic [2:0] src_r, src_nxt;
    logic [9:0] dly_r, dly_nxt;
    logic wake_ev, wd_edge, wd_cause, fault;

    // transceiver state on entry to restart or sleep
    function automatic logic [1:0] to_wake(input logic [1:0] m);
        to_wake = (m == `TRX_OFF) ? `TRX_OFF : `TRX_WAKE;
    endfunction

    // rising edge of the level, so a held wake makes one interrupt
    logic can_d_r, lin_d_r, wk_d_r;
    assign wake_ev = (can_w & ~can_d_r) | (lin_w & ~lin_d_r) | (wk_w & ~wk_d_r);
    assign wd_edge = wd_w & ~wdw_d_r;
    // with the reset limit enabled, after three resets missed triggers stop being a cause
    assign wd_cause = wd_edge & ~(rst_limit_en_i & (wdcnt_r == `WD_RST_LIMIT));
    // overvoltage counts only once enabled; the enable is low after reset
    assign fault = uv_w | (ov_w & ov_rst_en_i) | wd_cause;

    // ****
    // mode state machine
    // ****
    always_comb
    begin
        mode_nxt = mode_r;
        field_nxt = field_r;
        dev_nxt = dev_r;
        wdf_nxt = wdf_r;
        wdcnt_nxt = wdcnt_r;
        can_nxt = can_r;
        lin_nxt = lin_r;
        aux_nxt = aux_r;
        boost_nxt = boost_r;
        wkin_nxt = wkin_r;
        cyc_nxt = cyc_r;
        fo_nxt = fo_r;
        fsi_nxt = fsi_r;
        err_nxt = err_r;
        int_nxt = 1'b0;
        uvf_nxt = uvf_r;
        ovf_nxt = ovf_r;
        src_nxt = src_r;
        dly_nxt = dly_r;
        case (mode_r)
            sbc_mode_pkg::ST_INIT:
            begin
                // any command leaves init; peripherals start off
                if (spi_wr_i)
                begin
                    mode_nxt = sbc_mode_pkg::ST_NORMAL;
                    aux_nxt = 1'b0;
                    can_nxt = `TRX_OFF;
                    lin_nxt = `TRX_OFF;
                    fo_nxt = 1'b0;
                    fsi_nxt = 1'b1;
                end
            end
            sbc_mode_pkg::ST_NORMAL, sbc_mode_pkg::ST_STOP:
            begin
                // restart causes win over any host request this cycle
                if (fault)
                begin
                    mode_nxt = sbc_mode_pkg::ST_RESTART;
                    dev_nxt = `DEVICE_STATE_FIELD_FAULT;
                    uvf_nxt = uv_w;
                    ovf_nxt = ~uv_w & ov_w;
                    if (wd_cause)
                    begin
                        wdcnt_nxt = wdcnt_r + 2'h1;
                        wdf_nxt = wdcnt_r + 2'h1;
                    end
                end
                else
                begin
                    if (wake_ev)
                        int_nxt = 1'b1;
                    if (mode_r == sbc_mode_pkg::ST_NORMAL && spi_cfg_wr_i)
                    begin
                        // settings change only in normal, stop keeps them frozen
                        aux_nxt = aux_on_i;
                        boost_nxt = boost_on_i;
                        can_nxt = can_cfg_i;
                        lin_nxt = lin_cfg_i;
                        wkin_nxt = wake_in_en_i;
                        cyc_nxt = cyclic_en_i;
                        fsi_nxt = ~fsi_as_fo_i;
                    end
                    if (mode_r == sbc_mode_pkg::ST_STOP && spi_wr_i && !spi_exempt_i
                        && !(spi_mode_wr_i && spi_mode_i != `REQ_STOP))
                        err_nxt = 1'b1;
                    if (spi_mode_wr_i)
                    begin
                        field_nxt = spi_mode_i;
                        case (spi_mode_i)
                            `REQ_NORMAL: mode_nxt = sbc_mode_pkg::ST_NORMAL;
                            `REQ_STOP:
                                if (mode_r == sbc_mode_pkg::ST_NORMAL)
                                    mode_nxt = sbc_mode_pkg::ST_STOP;
                            `REQ_SLEEP:
                                if (mode_r == sbc_mode_pkg::ST_STOP)
                                begin
                                    err_nxt = 1'b1;
                                    mode_nxt = sbc_mode_pkg::ST_RESTART;
                                    dev_nxt = `DEVICE_STATE_FIELD_FAULT;
                                end
                                else if (wake_flags_set_i)
                                begin
                                    // pending wake flags: immediate wake
                                    mode_nxt = sbc_mode_pkg::ST_RESTART;
                                    dev_nxt = `DEVICE_STATE_FIELD_WAKE;
                                    wdf_nxt = `WATCHDOG_FAILURE_FIELD_NONE;
                                end
                                else
                                begin
                                    mode_nxt = sbc_mode_pkg::ST_SLEEP;
                                    can_nxt = to_wake(can_r);
                                    lin_nxt = to_wake(lin_r);
                                    boost_nxt = 1'b0;
                                end
                            default: mode_nxt = sbc_mode_pkg::ST_INIT;
                        endcase
                    end
                end
            end
            sbc_mode_pkg::ST_SLEEP:
            begin
                // spi is dropped entirely here; only wake ends sleep
                if (wake_ev)
                begin
                    mode_nxt = sbc_mode_pkg::ST_RESTART;
                    src_nxt = {wk_w, lin_w, can_w};
                    dev_nxt = `DEVICE_STATE_FIELD_WAKE;
                    wdf_nxt = `WATCHDOG_FAILURE_FIELD_NONE;
                    uvf_nxt = 1'b0;
                end
            end
            sbc_mode_pkg::ST_RESTART:
            begin
                // wait for cause gone and full delay, reset stays low
                if (uv_w || (ov_w && ov_rst_en_i))
                    dly_nxt = 10'h000;
                else if (dly_r == 10'(`RESET_DELAY_CYC - 1))
                begin
                    mode_nxt = sbc_mode_pkg::ST_NORMAL;
                    dly_nxt = 10'h000;
                end
                else
                    dly_nxt = dly_r + 10'h001;
            end
            default: mode_nxt = sbc_mode_pkg::ST_INIT;
        endcase
        // entry actions into restart; fail outputs deliberately untouched
        if (mode_nxt == sbc_mode_pkg::ST_RESTART && mode_r != sbc_mode_pkg::ST_RESTART)
        begin
            field_nxt = `REQ_NORMAL;
            aux_nxt = 1'b0;
            can_nxt = to_wake(can_r);
            lin_nxt = to_wake(lin_r);
            dly_nxt = 10'h000;
        end
        // test bit acts only while staying in normal; restart keeps fail outputs
        if (mode_r == sbc_mode_pkg::ST_NORMAL && mode_nxt == sbc_mode_pkg::ST_NORMAL)
            fo_nxt = fo_test_i;
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            mode_r <= sbc_mode_pkg::ST_INIT;
            field_r <= `REQ_NORMAL;
            dev_r <= `DEVICE_STATE_FIELD_RESET;
            wdf_r <= `WATCHDOG_FAILURE_FIELD_NONE;
            wdcnt_r <= 2'h0;
            can_r <= `TRX_OFF;
            lin_r <= `TRX_OFF;
            aux_r <= 1'b0;
            boost_r <= 1'b0;
            wkin_r <= 1'b0;
            cyc_r <= 1'b0;
            fo_r <= 1'b0;
            fsi_r <= 1'b1;
            err_r <= 1'b0;
            int_r <= 1'b0;
            uvf_r <= 1'b0;
            ovf_r <= 1'b0;
            src_r <= 3'h0;
            dly_r <= 10'h000;
            wdw_d_r <= 1'b0;
            can_d_r <= 1'b0;
            lin_d_r <= 1'b0;
            wk_d_r <= 1'b0;
        end
        else
        begin
            mode_r <= mode_nxt;
            field_r <= field_nxt;
            dev_r <= dev_nxt;
            wdf_r <= wdf_nxt;
            wdcnt_r <= wdcnt_nxt;
            can_r <= can_nxt;
            lin_r <= lin_nxt;
            aux_r <= aux_nxt;
            boost_r <= boost_nxt;
            wkin_r <= wkin_nxt;
            cyc_r <= cyc_nxt;
            fo_r <= fo_nxt;
            fsi_r <= fsi_nxt;
            err_r <= err_nxt;
            int_r <= int_nxt;
            uvf_r <= uvf_nxt;
            ovf_r <= ovf_nxt;
            src_r <= src_nxt;
            dly_r <= dly_nxt;
            wdw_d_r <= wd_w;
            can_d_r <= can_w;
            lin_d_r <= lin_w;
            wk_d_r <= wk_w;
        end
    end

    // ****
    // outputs
    // ****
    // sleep and restart both hold reset low; sleep entry drops it immediately
    assign reset_out_n_o = ~(mode_r == sbc_mode_pkg::ST_SLEEP
                             || mode_r == sbc_mode_pkg::ST_RESTART
                             || mode_r == sbc_mode_pkg::ST_INIT);
    // sleep and restart: spi not interpreted; only sleep gives no serial answer
    assign spi_ignore_o = (mode_r == sbc_mode_pkg::ST_SLEEP)
                          || (mode_r == sbc_mode_pkg::ST_RESTART);
    assign spi_sdo_en_o = (mode_r != sbc_mode_pkg::ST_SLEEP);
    assign mode_o = {mode_r[4] | mode_r[3], mode_r[2] | mode_r[3], mode_r[1]};
    assign mode_field_o = field_r;
    assign spi_err_o = err_r;
    assign wake_int_o = int_r;
    assign aux_on_o = aux_r;
    assign boost_on_o = boost_r;
    assign can_mode_o = can_r;
    assign lin_mode_o = lin_r;
    assign wake_in_en_o = wkin_r;
    assign cyclic_en_o = cyc_r;
    assign first_fail_output_o = fo_r;
    assign third_fail_output_o = fo_r;
    assign failsafe_input_en_o = fsi_r;
    assign dev_state_o = dev_r;
    assign watchdog_failure_field_o = wdf_r;
    assign uv_flag_o = uvf_r;
    assign ov_flag_o = ovf_r;
    assign wake_src_o = src_r;
endmodule

/* File: testbench/sbc_mode_props.sv */
// assertion checker of the operating-mode controller, bound to its ports
`timescale 1ns/1ps
module sbc_mode_props
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // watched inputs
    input wire logic spi_wr_i,
    input wire logic spi_mode_wr_i,
    input wire logic [1:0] spi_mode_i,
    input wire logic spi_exempt_i,
    input wire logic fo_test_i,
    input wire logic can_wake_i,
    // watched outputs
    input wire logic [2:0] mode_o,
    input wire logic [1:0] mode_field_o,
    input wire logic spi_err_o,
    input wire logic spi_sdo_en_o,
    input wire logic reset_out_n_o,
    input wire logic wake_int_o,
    input wire logic aux_on_o,
    input wire logic [1:0] can_mode_o,
    input wire logic [1:0] lin_mode_o,
    input wire logic first_fail_output_o,
    input wire logic third_fail_output_o
);
    // ****
    // properties, all in the one clock domain
    // ****
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // mode encodings: normal 1, stop 2, restart 4, sleep 6
    property p_sleep_rst; mode_o == 3'h6 |-> !reset_out_n_o; endproperty
    a_sleep_rst: assert property (p_sleep_rst) else $error("reset high in sleep");
    property p_restart_rst; mode_o == 3'h4 |-> !reset_out_n_o; endproperty
    a_restart_rst: assert property (p_restart_rst) else $error("reset high in restart");
    // one settled cycle allowed, the outputs are registered
    property p_restart_clr;
        mode_o == 3'h4 && $past(mode_o) == 3'h4 |-> !aux_on_o && mode_field_o == 2'h0;
    endproperty
    a_restart_clr: assert property (p_restart_clr) else $error("restart left state");
    property p_sleep_quiet; mode_o == 3'h6 |-> !spi_sdo_en_o; endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("serial out in sleep");
    property p_stop_err;
        mode_o == 3'h2 && spi_wr_i && !spi_exempt_i && !spi_mode_wr_i |=> spi_err_o;
    endproperty
    a_stop_err: assert property (p_stop_err) else $error("stop write not flagged");
    property p_stop_sleep;
        mode_o == 3'h2 && spi_mode_wr_i && spi_mode_i == 2'h1 |=> mode_o == 3'h4 && spi_err_o;
    endproperty
    a_stop_sleep: assert property (p_stop_sleep) else $error("stop to sleep taken");
    property p_stop_hold;
        mode_o == 3'h2 && $past(mode_o) == 3'h2 |->
            $stable(aux_on_o) && $stable(can_mode_o) && $stable(lin_mode_o);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("setting moved in stop");
    property p_sleep_trx;
        mode_o == 3'h6 && $past(mode_o) == 3'h6 |-> can_mode_o <= 2'h1 && lin_mode_o <= 2'h1;
    endproperty
    a_sleep_trx: assert property (p_sleep_trx) else $error("active transceiver asleep");
    // synchroniser stages plus the pulse register
    property p_wake_int; mode_o == 3'h1 && $rose(can_wake_i) |-> ##[1:8] wake_int_o; endproperty
    a_wake_int: assert property (p_wake_int) else $error("no wake pulse");
    property p_fo_test;
        (mode_o == 3'h1 && fo_test_i) [*3] |-> first_fail_output_o && third_fail_output_o;
    endproperty
    a_fo_test: assert property (p_fo_test) else $error("fail test not driven");
    c_sleep: cover property (mode_o == 3'h6);
    c_restart_exit: cover property (mode_o == 3'h4 ##1 mode_o == 3'h1);
    c_wake: cover property (wake_int_o);
endmodule
bind sbc_mode_ctrl sbc_mode_props i_sbc_mode_props
(
    .clk_i, .reset_n_i, .spi_wr_i, .spi_mode_wr_i, .spi_mode_i, .spi_exempt_i, .fo_test_i,
    .can_wake_i, .mode_o, .mode_field_o, .spi_err_o, .spi_sdo_en_o, .reset_out_n_o,
    .wake_int_o, .aux_on_o, .can_mode_o, .lin_mode_o, .first_fail_output_o,
    .third_fail_output_o
);

/* File: testbench/host_mcu.sv */
// host controller model: decoded spi frames and configuration levels
`timescale 1ns/1ps
module host_mcu
(
    // clock
    input wire logic clk_i,
    // frame strobes
    output logic spi_wr_o,
    output logic spi_mode_wr_o,
    output logic [1:0] spi_mode_o,
    output logic spi_exempt_o,
    output logic spi_cfg_wr_o,
    // configuration levels
    output logic aux_on_o,
    output logic boost_on_o,
    output logic [1:0] can_cfg_o,
    output logic [1:0] lin_cfg_o,
    output logic wake_in_en_o,
    output logic cyclic_en_o,
    output logic fsi_as_fo_o
);
    // idle lines at time zero
    initial
    begin
        {spi_wr_o, spi_mode_wr_o, spi_exempt_o, spi_cfg_wr_o, spi_mode_o} = 6'h00;
        {aux_on_o, boost_on_o, can_cfg_o, lin_cfg_o, wake_in_en_o, cyclic_en_o} = 8'h00;
        fsi_as_fo_o = 1'b0;
    end
    // one frame, strobes high for exactly one rising edge
    task automatic frame(input logic mw, input logic [1:0] m, input logic ex, input logic cw);
        @(negedge clk_i);
        {spi_wr_o, spi_mode_wr_o, spi_mode_o, spi_exempt_o, spi_cfg_wr_o} = {1'b1, mw, m, ex, cw};
        @(negedge clk_i);
        {spi_wr_o, spi_mode_wr_o, spi_exempt_o, spi_cfg_wr_o} = 4'h0;
        // flip stale mode lines so nothing leans on them
        spi_mode_o = ~m;
    endtask
    // levels only take effect with a later config frame
    task automatic set_cfg(input logic [7:0] v);
        {aux_on_o, boost_on_o, can_cfg_o, lin_cfg_o, wake_in_en_o, cyclic_en_o} = v;
    endtask
endmodule

/* File: testbench/sbc_mode_state_controller_bench.sv */
// self-checking bench of the operating-mode controller
`timescale 1ns/1ps
`include "sbc_mode_map.svh"
`define CHK(got, want) begin checks_done++; if ((got) !== (want)) begin err_total++; \
$display("unexpected at %0t: got %0h want %0h", $time, (got), (want)); end end
module sbc_mode_state_controller_bench;
    logic clk_i, reset_n_i, spi_wr_i, spi_mode_wr_i, spi_exempt_i, spi_cfg_wr_i, aux_on_i;
    logic [1:0] spi_mode_i, can_cfg_i, lin_cfg_i, mode_field_o, can_mode_o, lin_mode_o;
    logic boost_on_i, wake_in_en_i, cyclic_en_i, fo_test_i, fsi_as_fo_i, ov_rst_en_i;
    logic rst_limit_en_i, wake_flags_set_i, can_wake_i, lin_wake_i, wk_wake_i, uv_i, ov_i;
    logic watchdog_failure_field_i, spi_err_o, spi_ignore_o, spi_sdo_en_o, reset_out_n_o, wake_int_o;
    logic aux_on_o, boost_on_o, wake_in_en_o, cyclic_en_o, first_fail_output_o;
    logic third_fail_output_o, failsafe_input_en_o, uv_flag_o, ov_flag_o;
    logic [2:0] mode_o, wake_src_o;
    logic [1:0] dev_state_o, watchdog_failure_field_o;
    logic [7:0] cfg;
    int err_total = 0;
    int checks_done = 0;
    int seed = 44;
    int n_cyc, n_int = 0;
    // ****
    // design, host model and clock
    // ****
    sbc_mode_ctrl i_sbc_mode_ctrl
    (
        .clk_i, .reset_n_i, .spi_wr_i, .spi_mode_wr_i, .spi_mode_i, .spi_exempt_i, .spi_cfg_wr_i,
        .aux_on_i, .boost_on_i, .can_cfg_i, .lin_cfg_i, .wake_in_en_i, .cyclic_en_i, .fo_test_i,
        .fsi_as_fo_i, .ov_rst_en_i, .rst_limit_en_i, .wake_flags_set_i, .can_wake_i, .lin_wake_i,
        .wk_wake_i, .uv_i, .ov_i, .watchdog_failure_field_i, .mode_o, .mode_field_o, .spi_err_o, .spi_ignore_o,
        .spi_sdo_en_o, .reset_out_n_o, .wake_int_o, .aux_on_o, .boost_on_o, .can_mode_o,
        .lin_mode_o, .wake_in_en_o, .cyclic_en_o, .first_fail_output_o, .third_fail_output_o,
        .failsafe_input_en_o, .dev_state_o, .watchdog_failure_field_o, .uv_flag_o, .ov_flag_o, .wake_src_o
    );
    host_mcu i_host_mcu
    (
        .clk_i, .spi_wr_o(spi_wr_i), .spi_mode_wr_o(spi_mode_wr_i), .spi_mode_o(spi_mode_i),
        .spi_exempt_o(spi_exempt_i), .spi_cfg_wr_o(spi_cfg_wr_i), .aux_on_o(aux_on_i),
        .boost_on_o(boost_on_i), .can_cfg_o(can_cfg_i), .lin_cfg_o(lin_cfg_i),
        .wake_in_en_o(wake_in_en_i), .cyclic_en_o(cyclic_en_i), .fsi_as_fo_o(fsi_as_fo_i)
    );
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // wake pulses seen by the host
    always @(negedge clk_i) if (wake_int_o === 1'b1) n_int++;
    // ****
    // shared tasks
    // ****
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // bounded wait, cycles spent left in n_cyc
    task automatic wait_mode(input logic [2:0] m, input int lim);
        n_cyc = 0;
        while (mode_o !== m && n_cyc < lim)
        begin
            @(negedge clk_i);
            n_cyc++;
        end
        `CHK(mode_o, m)
    endtask
    // bench reference of the mode
    task automatic expect_mode(input int m);
        `CHK(mode_o, m[2:0])
    endtask
    // long enough to pass the pin agreement filter
    task automatic pulse(ref logic p);
        p = 1'b1;
        repeat (8) @(negedge clk_i);
        p = 1'b0;
    endtask
    // hang guard, well past the longest sequence
    initial
    begin
        #(20 * 20000);
        err_total++;
        report_and_stop();
    end
    // ****
    // main sequence
    // ****
    initial
    begin
        reset_n_i = 1'b0;
        {fo_test_i, ov_rst_en_i, rst_limit_en_i, wake_flags_set_i} = 4'h0;
        {can_wake_i, lin_wake_i, wk_wake_i, uv_i, ov_i, watchdog_failure_field_i} = 6'h00;
        repeat (16) @(negedge clk_i);
        reset_n_i = 1'b1;
        expect_mode(0);
        `CHK(reset_out_n_o, 1'b0)
        i_host_mcu.frame(1'b1, `REQ_NORMAL, 1'b0, 1'b0);
        expect_mode(1);
        `CHK({reset_out_n_o, aux_on_o, can_mode_o, lin_mode_o}, 6'h20)
        `CHK({first_fail_output_o, third_fail_output_o, failsafe_input_en_o}, 3'h1)
        fo_test_i = 1'b1;
        repeat (3) @(negedge clk_i);
        `CHK({first_fail_output_o, third_fail_output_o}, 2'h3)
        fo_test_i = 1'b0;
        repeat (3) @(negedge clk_i);
        `CHK({first_fail_output_o, third_fail_output_o}, 2'h0)
        pulse(can_wake_i);
        repeat (4) @(negedge clk_i);
        `CHK(n_int, 1)
        expect_mode(1);
        $display("test normal mode done");
        cfg = 8'($random(seed));
        i_host_mcu.set_cfg(cfg);
        i_host_mcu.frame(1'b0, `REQ_NORMAL, 1'b0, 1'b1);
        i_host_mcu.frame(1'b1, `REQ_STOP, 1'b0, 1'b0);
        expect_mode(2);
        i_host_mcu.frame(1'b0, `REQ_NORMAL, 1'b1, 1'b0);
        `CHK(spi_err_o, 1'b0)
        i_host_mcu.set_cfg(~cfg);
        i_host_mcu.frame(1'b0, `REQ_NORMAL, 1'b0, 1'b1);
        `CHK(spi_err_o, 1'b1)
        `CHK({aux_on_o, boost_on_o, can_mode_o, lin_mode_o, wake_in_en_o, cyclic_en_o}, cfg)
        fo_test_i = 1'b1;
        repeat (3) @(negedge clk_i);
        `CHK(first_fail_output_o, 1'b0)
        fo_test_i = 1'b0;
        pulse(lin_wake_i);
        repeat (4) @(negedge clk_i);
        `CHK(n_int, 2)
        expect_mode(2);
        i_host_mcu.frame(1'b1, `REQ_SLEEP, 1'b0, 1'b0);
        expect_mode(4);
        wait_mode(3'h1, 700);
        `CHK(n_cyc, `RESET_DELAY_CYC)
        `CHK({reset_out_n_o, mode_field_o, dev_state_o}, {1'b1, 2'h0, `DEVICE_STATE_FIELD_FAULT})
        $display("test stop mode done");
        // active transceivers, auxiliary on
        i_host_mcu.set_cfg({1'b1, cfg[6], 2'h3, 2'h2, cfg[1:0]});
        i_host_mcu.frame(1'b0, `REQ_NORMAL, 1'b0, 1'b1);
        i_host_mcu.frame(1'b1, `REQ_SLEEP, 1'b0, 1'b0);
        `CHK(reset_out_n_o, 1'b0)
        @(negedge clk_i);
        expect_mode(6);
        `CHK({can_mode_o, lin_mode_o, spi_sdo_en_o, spi_ignore_o}, 6'h15)
        i_host_mcu.frame(1'b1, `REQ_NORMAL, 1'b0, 1'b0);
        expect_mode(6);
        pulse(wk_wake_i);
        wait_mode(3'h4, 8);
        expect_mode(4);
        `CHK({aux_on_o, can_mode_o, lin_mode_o, spi_ignore_o}, 6'h0b)
        wait_mode(3'h1, 700);
        `CHK({dev_state_o, watchdog_failure_field_o, wake_src_o}, {`DEVICE_STATE_FIELD_WAKE, `WATCHDOG_FAILURE_FIELD_NONE, 3'h4})
        $display("test sleep mode done");
        pulse(uv_i);
        expect_mode(4);
        wait_mode(3'h1, 700);
        `CHK({uv_flag_o, ov_flag_o}, 2'h2)
        pulse(ov_i);
        expect_mode(1);
        ov_rst_en_i = 1'b1;
        pulse(ov_i);
        expect_mode(4);
        wait_mode(3'h1, 700);
        `CHK({uv_flag_o, ov_flag_o}, 2'h1)
        $display("test supply faults done");
        wake_flags_set_i = 1'b1;
        i_host_mcu.frame(1'b1, `REQ_SLEEP, 1'b0, 1'b0);
        wait_mode(3'h4, 8);
        expect_mode(4);
        wake_flags_set_i = 1'b0;
        wait_mode(3'h1, 700);
        rst_limit_en_i = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            pulse(watchdog_failure_field_i);
            expect_mode(i < 3 ? 4 : 1);
            wait_mode(3'h1, 700);
        end
        $display("test watchdog limit done");
        report_and_stop();
    end
endmodule
